// [hdl/pin_sync.sv]
/*
  Three-stage synchroniser for a bus of pin inputs with agreement filter.
  Assumes inputs are asynchronous to sys_clk; output holds until
  stages two and three agree.
*/
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] out_r;
  } sync_t;

  sync_t st_r;
  sync_t st_nxt;

  // ****************************************************************
  // shift chain; stage one feeds only stage two
  // ****************************************************************
  always_comb begin
    st_nxt      = st_r;
    st_nxt.s1_r = pin_in;
    st_nxt.s2_r = st_r.s1_r;
    st_nxt.s3_r = st_r.s2_r;
    // per bit: accept only when the two settled stages agree
    for (int i = 0; i < WIDTH; i++) begin
      if (st_r.s2_r[i] == st_r.s3_r[i]) begin
        st_nxt.out_r[i] = st_r.s3_r[i];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pin_out = st_r.out_r;

endmodule
`default_nettype wire

// [hdl/status_output.sv]
/*
  Assignable status output: eight drive conditions selected, inverted
  and combined onto the single open-collector output pin, plus option
  switch storage, serial framing settings and an interrupt block.
  Assumes condition inputs arrive from pins and are synchronised here,
  and that software uses the one-cycle strobe register port.
*/
// The implementer's own choices: the register offsets and the strobed register port.
// Operation
// - the frequency output pin can be switched over to status output use
// - any mix of eight conditions drives the output via assignment mask
// - selectable conditions are the drive status word bits
// - per-condition inverter mask swaps a condition for its complement
// - an output selection picks normally open or normally closed
// - assignment weight 1 selects pickup stalled
// - weight 32 upper limit, 16 lower limit; both give either alarm
// - selection 0 is normally open; inverter 0 inverts nothing
// - an option-switch setting holds up to eight switches in one value
// - switch n carries weight two to the power n minus one
// - stored value is the sum of on-switch weights; write sets them
// - reading returns the same weighted sum
// - serial port defaults to 300 baud, 8 data bits, 1 stop bit
// - a board strap selects rs232 or rs422/485 operation
`timescale 1ns/1ns
`default_nettype none
module status_output
  import uao_pkg::*;
#(
  parameter int NCOND = NUM_COND
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [31:0]      reg_rdata,
  input  wire logic [NCOND-1:0] drive_status,
  input  wire logic             rs485_strap,
  input  wire logic [15:0]      freq_gen_in,
  output logic                  out_pin_o,
  output logic                  out_pin_oe_n,
  output logic                  irq
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [7:0]       assign_r;
    logic [7:0]       invert_r;
    logic             outsel_r;
    logic             status_mode_r;
    logic [7:0]       optsw_r;
    logic [15:0]      baud_r;
    logic [3:0]       dbits_r;
    logic [1:0]       sbits_r;
    logic             rs485_r;
    logic [NCOND-1:0] cond_prev_r;
    logic             out_prev_r;
    logic [9:0]       irq_st_r;
    logic [9:0]       irq_msk_r;
    logic             drive_r;
    logic [31:0]      rdata_r;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic [NCOND-1:0] cond_sync;
  logic             strap_sync;
  logic             combined;
  logic             level;
  logic [9:0]       events;

  // ****************************************************************
  // pin synchronisers for conditions and the board strap
  // ****************************************************************
  pin_sync #(
    .WIDTH (NCOND)
  ) u_cond_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .pin_in  (drive_status),
    .pin_out (cond_sync)
  );

  pin_sync #(
    .WIDTH (1)
  ) u_strap_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .pin_in  (rs485_strap),
    .pin_out (strap_sync)
  );

  // ****************************************************************
  // functions
  // ****************************************************************
  // selected, per-bit inverted conditions ORed together
  function automatic logic combine(input logic [7:0] c,
                                   input logic [7:0] sel,
                                   input logic [7:0] inv);
    combine = |(sel & (c ^ inv));
  endfunction

  // zero extend a byte setting to a bus word
  function automatic logic [31:0] word8(input logic [7:0] v);
    word8 = {24'h000000, v};
  endfunction

  // ****************************************************************
  // output path; level combinational from synced inputs and settings, pin drive registered in drive_r
  // ****************************************************************
  // conditions are the drive status bits, weight 1 = pickup stalled
  assign combined = combine(cond_sync, st_r.assign_r, st_r.invert_r);
  // selection 0 passes, 1 complements
  assign level    = st_r.outsel_r ? ~combined : combined;

  // events: output edges and condition rises
  assign events = {cond_sync & ~st_r.cond_prev_r,
                   ~level & st_r.out_prev_r,
                   level & ~st_r.out_prev_r};

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_nxt             = st_r;
    st_nxt.cond_prev_r = cond_sync;
    st_nxt.out_prev_r  = level;
    st_nxt.rdata_r     = 32'h0000_0000;

    // strap is a static level; a one-shot catch right after reset would
    // only see the still-empty synchroniser, so follow it instead
    st_nxt.rs485_r = strap_sync;

    // sticky interrupt flags; a set in the clear cycle wins
    if (reg_wr && reg_addr == ADDR_IRQ_ST) begin
      st_nxt.irq_st_r = st_r.irq_st_r & ~reg_wdata[9:0];
    end
    st_nxt.irq_st_r = st_nxt.irq_st_r | events;

    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_ASSIGN:  st_nxt.assign_r = reg_wdata[7:0];
        ADDR_INVERT:  st_nxt.invert_r = reg_wdata[7:0];
        ADDR_OUTSEL: begin
          st_nxt.outsel_r      = reg_wdata[0];
          st_nxt.status_mode_r = reg_wdata[1];
        end
        // the switch bank is stored as its weighted sum
        ADDR_OPTSW:   st_nxt.optsw_r  = reg_wdata[7:0];
        ADDR_SERIAL: begin
          st_nxt.baud_r  = reg_wdata[SER_BAUD_LSB +: 16];
          st_nxt.dbits_r = reg_wdata[SER_DBITS_LSB +: 4];
          st_nxt.sbits_r = reg_wdata[SER_SBITS_LSB +: 2];
        end
        ADDR_IRQ_MSK: st_nxt.irq_msk_r = reg_wdata[9:0];
        default: ;
      endcase
    end

    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_ASSIGN:  st_nxt.rdata_r = word8(st_r.assign_r);
        ADDR_INVERT:  st_nxt.rdata_r = word8(st_r.invert_r);
        ADDR_OUTSEL:  st_nxt.rdata_r = {29'h0, level,
                                        st_r.status_mode_r, st_r.outsel_r};
        ADDR_STATUS:  st_nxt.rdata_r = word8(cond_sync);
        ADDR_OPTSW:   st_nxt.rdata_r = word8(st_r.optsw_r);
        ADDR_SERIAL:  st_nxt.rdata_r = {7'h00, st_r.rs485_r, 2'h0,
                                        st_r.sbits_r, st_r.dbits_r,
                                        st_r.baud_r};
        ADDR_IRQ_ST:  st_nxt.rdata_r = {22'h0, st_r.irq_st_r};
        ADDR_IRQ_MSK: st_nxt.rdata_r = {22'h0, st_r.irq_msk_r};
        default:      st_nxt.rdata_r = UNMAPPED_READ;
      endcase
    end

    // open collector sinks when active; frequency gen otherwise
    st_nxt.drive_r = st_r.status_mode_r ? level : freq_gen_in[0];
  end

  // ****************************************************************
  // registers; serial defaults match shipment framing
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_r           <= '0;
      st_r.assign_r  <= RST_ASSIGN;
      st_r.invert_r  <= RST_INVERT;
      st_r.outsel_r  <= RST_OUTSEL;
      st_r.optsw_r   <= RST_OPTSW;
      st_r.baud_r    <= RST_BAUD;
      st_r.dbits_r   <= RST_DBITS;
      st_r.sbits_r   <= RST_SBITS;
      st_r.irq_msk_r <= RST_IRQ_MSK;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign reg_rdata    = st_r.rdata_r;
  assign out_pin_o    = 1'b0;              // open collector only sinks
  assign out_pin_oe_n = ~st_r.drive_r;     // low while sinking
  assign irq          = |(st_r.irq_st_r & st_r.irq_msk_r);

  // ****************************************************************
  // checks
  // ****************************************************************
  a_out_follows: assert property (@(posedge sys_clk) disable iff (reset)
    st_r.status_mode_r && $stable(st_r.status_mode_r) |=>
      (st_r.drive_r == $past(level)))
    else $error("output drive does not follow combined level");

  a_nc_inverts: assert property (@(posedge sys_clk) disable iff (reset)
    st_r.outsel_r && st_r.assign_r == 8'h01 && st_r.invert_r == 8'h00
      |-> level == !cond_sync[COND_PICKUP_STALL])
    else $error("normally closed selection not complemented");

  a_no_assign_idle: assert property (@(posedge sys_clk) disable iff (reset)
    st_r.assign_r == 8'h00 && !st_r.outsel_r |-> !level)
    else $error("empty mask must leave output inactive");

  a_stall_sel: assert property (@(posedge sys_clk) disable iff (reset)
    st_r.assign_r == 8'h01 && st_r.invert_r == 8'h00 && !st_r.outsel_r
      |-> level == cond_sync[COND_PICKUP_STALL])
    else $error("weight one does not pick pickup stall");

  a_limit_pair: assert property (@(posedge sys_clk) disable iff (reset)
    st_r.assign_r == 8'h30 && st_r.invert_r == 8'h00 && !st_r.outsel_r
      |-> level == (cond_sync[COND_UPPER_LIMIT] |
                    cond_sync[COND_LOWER_LIMIT]))
    else $error("limit pair not ORed");

  a_optsw_back: assert property (@(posedge sys_clk) disable iff (reset)
    reg_wr && reg_addr == ADDR_OPTSW ##1 reg_rd && reg_addr == ADDR_OPTSW
      |=> reg_rdata == word8($past(reg_wdata[7:0], 2)))
    else $error("option switch value not read back");

  a_irq_sticky: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(level) && st_r.out_prev_r == 1'b0 |=> st_r.irq_st_r[IRQ_OUT_RISE])
    else $error("output rise not recorded");

  a_serial_dflt: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(reset) |-> st_r.baud_r == RST_BAUD && st_r.dbits_r == RST_DBITS)
    else $error("serial defaults wrong after reset");

endmodule
`default_nettype wire

// [hdl/uao_pkg.sv]
/*
  Package for the assignable status output block: register offsets,
  field positions, reset values and serial framing constants.
  Assumes a single 10 MHz clock domain and a plain strobe register port.
*/
package uao_pkg;

  // ****************************************************************
  // register offsets (byte addresses, one word each)
  // ****************************************************************
  localparam logic [7:0] ADDR_ASSIGN  = 8'h00;
  localparam logic [7:0] ADDR_INVERT  = 8'h04;
  localparam logic [7:0] ADDR_OUTSEL  = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0C;
  localparam logic [7:0] ADDR_SERIAL  = 8'h10;
  localparam logic [7:0] ADDR_OPTSW   = 8'h14;
  localparam logic [7:0] ADDR_IRQ_ST  = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MSK = 8'h1C;

  // ****************************************************************
  // condition bit positions in the drive status word
  // ****************************************************************
  localparam int COND_PICKUP_STALL = 0;  // weight 1
  localparam int COND_LOWER_LIMIT  = 4;  // weight 16
  localparam int COND_UPPER_LIMIT  = 5;  // weight 32
  localparam int NUM_COND          = 8;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] RST_ASSIGN = 8'h00;
  localparam logic [7:0] RST_INVERT = 8'h00;
  localparam logic       RST_OUTSEL = 1'b0;   // normally open
  localparam logic [7:0] RST_OPTSW  = 8'h00;
  localparam logic [7:0] RST_IRQ_MSK = 8'h00;

  // serial control field positions
  localparam int SER_BAUD_LSB  = 0;   // 16-bit baud value
  localparam int SER_DBITS_LSB = 16;  // 4-bit data bit count
  localparam int SER_SBITS_LSB = 20;  // 2-bit stop bit count
  localparam int SER_MODE_BIT  = 24;  // read only: 1 = rs422/485

  // shipment framing
  localparam logic [15:0] RST_BAUD  = 16'h012C;  // 300 baud
  localparam logic [3:0]  RST_DBITS = 4'h8;
  localparam logic [1:0]  RST_SBITS = 2'h1;

  // interrupt status bit positions
  localparam int IRQ_OUT_RISE = 0;
  localparam int IRQ_OUT_FALL = 1;
  localparam int IRQ_COND_LSB = 2;   // bits 9:2 follow condition rises

  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

endpackage

// [sim/assignable_status_output_tb_top.sv]
/*
  Self-checking bench for the status output block: register access,
  output combining, option switches and interrupts.
  Assumes the one-cycle strobe register port and a 10 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
module assignable_status_output_tb_top;
  import uao_pkg::*;

  logic        sys_clk;
  logic        reset;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [7:0]  drive_status;
  logic [15:0] freq_gen_in;
  logic        rs485_strap;
  logic        out_pin_o;
  logic        out_pin_oe_n;
  logic        irq;
  logic        lamp_on;
  int          err_count;
  int          cmp_count;
  int          cycles;
  // assign, invert, outsel, status, expected lamp
  logic [7:0]  tbl_a [9] = '{8'h01, 8'h01, 8'h30, 8'h30, 8'h30,
                              8'h01, 8'h01, 8'h01, 8'hFF};
  logic [7:0]  tbl_i [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                              8'h01, 8'h00, 8'h00, 8'hFF};
  logic        tbl_o [9] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
                              1'b0, 1'b1, 1'b1, 1'b0};
  logic [7:0]  tbl_s [9] = '{8'h01, 8'h00, 8'h10, 8'h20, 8'h02,
                              8'h00, 8'h00, 8'h01, 8'hFF};
  logic        tbl_e [9] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0,
                              1'b1, 1'b1, 1'b0, 1'b0};
  logic [7:0]  opt_v [5] = '{8'h49, 8'hFF, 8'h0B, 8'h01, 8'h80};

  status_output u_dut (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_wr       (reg_wr),
    .reg_rd       (reg_rd),
    .reg_rdata    (reg_rdata),
    .drive_status (drive_status),
    .rs485_strap  (rs485_strap),
    .freq_gen_in  (freq_gen_in),
    .out_pin_o    (out_pin_o),
    .out_pin_oe_n (out_pin_oe_n),
    .irq          (irq)
  );

  indicator_model u_lamp (
    .pin_o    (out_pin_o),
    .pin_oe_n (out_pin_oe_n),
    .lamp_on  (lamp_on)
  );

  // ****************************************************************
  // clock, timeout and shared tasks
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // the whole run needs well under 2000 cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
                       input string nm);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(nm, exp, reg_rdata);
  endtask

  // write then read back with no gap between the two strobes
  task automatic wrrd(input logic [7:0] a, input logic [31:0] d,
                      input string nm);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    @(posedge sys_clk);
    reg_rd    <= 1'b0;
    #1;
    chk(nm, d, reg_rdata);
  endtask

  // pins pass a synchroniser, so allow it to settle
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    err_count = 0;
    cmp_count = 0;
    cycles = 0;
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    drive_status = 8'h00;
    freq_gen_in = 16'h0;
    rs485_strap = 1'b0;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    // reset values and shipment framing
    rdchk(ADDR_ASSIGN, 32'h0, "assign");
    rdchk(ADDR_INVERT, 32'h0, "invert");
    rdchk(ADDR_OUTSEL, 32'h0, "outsel");
    rdchk(ADDR_SERIAL, {8'h00, 2'h0, RST_SBITS, RST_DBITS, RST_BAUD},
          "serial");
    rdchk(ADDR_IRQ_MSK, 32'h0, "mask");
    rdchk(8'h20, 32'h0, "unmapped");
    $display("test reset_values done");
    // option switches round trip their weighted sum
    for (int k = 0; k < 5; k++) begin
      wrrd(ADDR_OPTSW, {24'h0, opt_v[k]}, "optsw");
    end
    $display("test option_switches done");
    // host side keeps no handshake lines and expects no echo; framing
    // is rewritable, the strap bit is read only and follows the strap
    wr(ADDR_SERIAL, 32'h0127_2580);
    rdchk(ADDR_SERIAL, 32'h0027_2580, "serial_wr");
    rs485_strap <= 1'b1;
    settle(8);
    rdchk(ADDR_SERIAL, 32'h0127_2580, "serial_strap");
    rs485_strap <= 1'b0;
    settle(8);
    rdchk(ADDR_SERIAL, 32'h0027_2580, "serial_unstrap");
    $display("test serial_settings done");
    // frequency source owns the pin while status mode is off
    freq_gen_in <= 16'h0001;
    settle(8);
    chk("freq_on", 32'h1, {31'h0, lamp_on});
    freq_gen_in <= 16'h0000;
    settle(8);
    chk("freq_off", 32'h0, {31'h0, lamp_on});
    $display("test freq_mode done");
    // status mode combining table
    for (int k = 0; k < 9; k++) begin
      wr(ADDR_ASSIGN, {24'h0, tbl_a[k]});
      wr(ADDR_INVERT, {24'h0, tbl_i[k]});
      wr(ADDR_OUTSEL, {30'h0, 1'b1, tbl_o[k]});
      drive_status <= tbl_s[k];
      settle(8);
      chk("lamp", {31'h0, tbl_e[k]}, {31'h0, lamp_on});
      rdchk(ADDR_STATUS, {24'h0, tbl_s[k]}, "status");
    end
    $display("test combining done");
    // interrupt on output rise, cleared by writing one, then masked
    wr(ADDR_ASSIGN, 32'h1);
    wr(ADDR_INVERT, 32'h0);
    wr(ADDR_OUTSEL, 32'h2);
    drive_status <= 8'h00;
    settle(8);
    wr(ADDR_IRQ_ST, 32'h3FF);
    wr(ADDR_IRQ_MSK, 32'h1);
    settle(2);
    chk("irq_idle", 32'h0, {31'h0, irq});
    drive_status <= 8'h01;
    settle(8);
    chk("irq_rise", 32'h1, {31'h0, irq});
    wr(ADDR_IRQ_ST, 32'h1);
    settle(2);
    chk("irq_clr", 32'h0, {31'h0, irq});
    wr(ADDR_IRQ_MSK, 32'h0);
    drive_status <= 8'h00;
    settle(8);
    drive_status <= 8'h01;
    settle(8);
    chk("irq_masked", 32'h0, {31'h0, irq});
    rdchk(ADDR_IRQ_ST, 32'h7, "irq_status");
    $display("test interrupts done");
    conclude();
  end
endmodule
`default_nettype wire

// [sim/indicator_model.sv]
/*
  Indicator load model on the open-collector status output.
  Assumes a pull-up on the pin and that sinking current lights the lamp.
*/
`timescale 1ns/1ns
`default_nettype none
module indicator_model (
  input  wire logic pin_o,
  input  wire logic pin_oe_n,
  output logic      lamp_on
);
  logic pin_level;

  // released pin floats up through the pull-up, never holds the last value
  assign pin_level = pin_oe_n ? 1'b1 : pin_o;
  // lamp lights only while the transistor pulls the pin low
  assign lamp_on   = ~pin_level;
endmodule
`default_nettype wire
